// [common/tjm_pkg.sv]
// What this block does
// - majority zero keeps j bit, else drop
// - sink store written by gapped clock
// - sink store read by smoothed clock
// - sink store deep enough for jitter
// - sink recovers after frequency step quickly
// - sink extracts only selected slot
// - inactive sink sends ones, hides status
// - trail fail raises fail, ones output
// - fail removed resumes data within bound
// - mapper fills selected slot, 205 bits plus j bit
// - mapper store written by tributary clock
// - mapper reads by aggregate clock, position
// - justification skips read, j bit empty
// - mapper inserts control bits per decision
// - mapper store absorbs jitter and offset
// - mapper writes only selected slot
// - mapper drives aggregate only when active
// - three control bits, set equal, voted
package tjm_pkg;
   // -----------------------------------------------------------------
   // frame layout (848 bits, four interleaved slots)
   // -----------------------------------------------------------------
   localparam int unsigned FRAME_BITS = 848;
   localparam int unsigned SLOT_COUNT = 4;
   localparam int unsigned SLOT_PAYLOAD_BITS = 209;
   localparam int unsigned OVERHEAD_END = 12;
   localparam int unsigned SET_BITS = 212;
   localparam int unsigned CTRL_BITS = 4;
   localparam int unsigned J_POS = 216;
   localparam logic [9:0] FRAME_LAST = 10'h34f;
   // -----------------------------------------------------------------
   // elastic stores
   // -----------------------------------------------------------------
   localparam int unsigned STORE_AW = 5;
   localparam int unsigned STORE_DEPTH = 32;
   localparam logic [4:0] STORE_HALF = 5'h10;
   localparam logic [4:0] JUST_THRESHOLD = 5'h0c;
   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned FAIL_LIMIT_US = 600;
   localparam int unsigned FAIL_LIMIT_CYCLES = FAIL_LIMIT_US * CLK_MHZ;
   localparam int unsigned RECOVERY_S = 1;
   // smoothed tributary bit period: 100 MHz / 2.048 MHz = 48.828 cycles
   localparam logic [15:0] NCO_STEP_NOM = 16'h053e;
   localparam logic [15:0] NCO_TRIM_MAX = 16'h0002;
   typedef enum logic [1:0] {TJM_IDLE = 2'b00, TJM_RUN = 2'b01, TJM_FAIL = 2'b11} tjm_state_t;
endpackage

// [hw/tjm_store.sv]
// dual-clock elastic store, gray write pointer crosses to the read side only
module tjm_store (
   input wire logic wclk_i,
   input wire logic wrst_i,
   input wire logic we_i,
   input wire logic wd_i,
   input wire logic rclk_i,
   input wire logic rrst_i,
   input wire logic re_i,
   output logic rd_o,
   output logic [4:0] rfill_o
);
   logic mem_q [tjm_pkg::STORE_DEPTH];
   logic [4:0] wp_q;
   logic [4:0] wg_q;
   logic [4:0] rp_q;
   logic [4:0] wg1_q;
   logic [4:0] wg2_q;
   logic [4:0] wbin;
   always_ff @(posedge wclk_i)
   begin
      if (wrst_i)
      begin
         wp_q <= 5'h00;
         wg_q <= 5'h00;
      end
      else if (we_i)
      begin
         mem_q[wp_q] <= wd_i;
         wp_q <= wp_q + 5'h01;
         wg_q <= (wp_q + 5'h01) ^ ((wp_q + 5'h01) >> 1);
      end
   end
   always_comb
   begin
      wbin[4] = wg2_q[4];
      for (int k = 3; k >= 0; k--)
         wbin[k] = wbin[k+1] ^ wg2_q[k];
   end
   assign rfill_o = wbin - rp_q;
   always_ff @(posedge rclk_i)
   begin
      if (rrst_i)
      begin
         wg1_q <= 5'h00;
         wg2_q <= 5'h00;
         rp_q <= 5'h00;
         rd_o <= 1'b1;
      end
      else
      begin
         wg1_q <= wg_q;
         wg2_q <= wg1_q;
         if (re_i && rfill_o != 5'h00)
         begin
            rd_o <= mem_q[rp_q];
            rp_q <= rp_q + 5'h01;
         end
      end
   end
endmodule

// [hw/tjm_sync3.sv]
module tjm_sync3 (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic d_i,
   output logic q_o
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         q_o <= 1'b0;
      end
      else
      begin
         s1_q <= d_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            q_o <= s3_q;
      end
   end
endmodule

// [hw/tjm_top.sv]
// mapper/demapper for one 2 Mbit/s tributary in an 8 Mbit/s frame
module tjm_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [1:0] slot_index_i,
   // mapper side
   input wire logic trib_clk_i,
   input wire logic trib_rst_i,
   input wire logic trib_data_i,
   input wire logic aggregate_timing_clock_i,
   input wire logic agg_rst_i,
   input wire logic aggregate_frame_start_i,
   input wire logic map_activate_i,
   output logic agg_data_o,
   output logic agg_data_oe_o,
   // demapper side
   input wire logic agg_rx_clk_i,
   input wire logic agg_rx_rst_i,
   input wire logic agg_rx_data_i,
   input wire logic agg_rx_frame_start_i,
   input wire logic trail_fail_in_i,
   input wire logic function_activate_i,
   output logic tributary_data_out_o,
   output logic tributary_clk_o,
   output logic server_fail_out_o,
   output logic status_valid_o
);
   // -----------------------------------------------------------------
   // frame position decode shared by both directions
   // -----------------------------------------------------------------
   function automatic logic [2:0] pos_kind(input logic [9:0] pos, input logic [1:0] slot);
      logic [9:0] inset;
      logic [7:0] setpos;
      pos_kind = 3'd0;
      inset = pos % 10'(tjm_pkg::SET_BITS);
      setpos = 8'(inset);
      // 0 none, 1 data, 2 control, 3 justification opportunity
      if (pos[1:0] == slot)
      begin
         if (pos < 10'(tjm_pkg::SET_BITS) && setpos < 8'(tjm_pkg::OVERHEAD_END))
            pos_kind = 3'd0;
         else if (pos >= 10'(tjm_pkg::SET_BITS) && setpos < 8'(tjm_pkg::CTRL_BITS))
            pos_kind = 3'd2;
         else if (pos >= 10'(3 * tjm_pkg::SET_BITS) && setpos < 8'(tjm_pkg::CTRL_BITS + 4))
            pos_kind = 3'd3;
         else
            pos_kind = 3'd1;
      end
   endfunction

   // -----------------------------------------------------------------
   // mapper: store written on tributary clock
   // -----------------------------------------------------------------
   logic map_rd;
   logic [4:0] map_fill;
   logic map_re;
   logic [9:0] mpos_q;
   logic just_q;
   logic [2:0] mkind;
   tjm_store map_store (
      .wclk_i(trib_clk_i),
      .wrst_i(trib_rst_i),
      .we_i(1'b1),
      .wd_i(trib_data_i),
      .rclk_i(aggregate_timing_clock_i),
      .rrst_i(agg_rst_i),
      .re_i(map_re),
      .rd_o(map_rd),
      .rfill_o(map_fill)
   );
   assign mkind = pos_kind(mpos_q, slot_index_i);
   assign map_re = (mkind == 3'd1) || (mkind == 3'd3 && !just_q);

   always_ff @(posedge aggregate_timing_clock_i)
   begin
      if (agg_rst_i)
      begin
         mpos_q <= 10'h000;
         just_q <= 1'b0;
      end
      else
      begin
         // position one ahead of the output register
         if (aggregate_frame_start_i || mpos_q == tjm_pkg::FRAME_LAST)
            mpos_q <= 10'h000;
         else
            mpos_q <= mpos_q + 10'h001;
         // decision taken once per frame; store running low means stuff
         if (aggregate_frame_start_i)
            just_q <= (map_fill < tjm_pkg::JUST_THRESHOLD);
      end
   end

   logic map_active_q;
   logic map_drive_q;
   logic map_bit_q;
   always_ff @(posedge aggregate_timing_clock_i)
   begin
      if (agg_rst_i)
      begin
         map_active_q <= 1'b0;
         map_drive_q <= 1'b0;
         map_bit_q <= 1'b0;
      end
      else
      begin
         map_active_q <= map_activate_i;
         map_drive_q <= map_active_q && (mkind != 3'd0);
         case (mkind)
            3'd1: map_bit_q <= map_rd;
            3'd2: map_bit_q <= just_q;
            3'd3: map_bit_q <= just_q ? 1'b0 : map_rd;
            default: map_bit_q <= 1'b0;
         endcase
      end
   end
   assign agg_data_o = map_bit_q;
   assign agg_data_oe_o = map_drive_q;

   // -----------------------------------------------------------------
   // demapper: vote on control bits, gapped write
   // -----------------------------------------------------------------
   logic [9:0] dpos_q;
   logic [1:0] vote_q;
   logic [2:0] dkind;
   logic vote_one;
   logic dm_we;
   assign dkind = pos_kind(dpos_q, slot_index_i);
   assign vote_one = vote_q[1]; // two or three of three ones
   assign dm_we = (dkind == 3'd1) || (dkind == 3'd3 && !vote_one);

   always_ff @(posedge agg_rx_clk_i)
   begin
      if (agg_rx_rst_i)
      begin
         dpos_q <= 10'h000;
         vote_q <= 2'b00;
      end
      else
      begin
         if (agg_rx_frame_start_i || dpos_q == tjm_pkg::FRAME_LAST)
            dpos_q <= 10'h000;
         else
            dpos_q <= dpos_q + 10'h001;
         if (agg_rx_frame_start_i)
            vote_q <= 2'b00;
         else if (dkind == 3'd2 && agg_rx_data_i && vote_q != 2'b11)
            vote_q <= vote_q + 2'b01;
      end
   end

   logic dm_rd;
   logic [4:0] dm_fill;
   logic smooth_tick;
   tjm_store dm_store (
      .wclk_i(agg_rx_clk_i),
      .wrst_i(agg_rx_rst_i),
      .we_i(dm_we),
      .wd_i(agg_rx_data_i),
      .rclk_i(clk_i),
      .rrst_i(rst_i),
      .re_i(smooth_tick),
      .rd_o(dm_rd),
      .rfill_o(dm_fill)
   );

   // -----------------------------------------------------------------
   // smoothed read clock: nco trimmed by store fill
   // -----------------------------------------------------------------
   logic [15:0] nco_q;
   logic [15:0] step;
   logic [16:0] nco_sum;
   assign step = (dm_fill > tjm_pkg::STORE_HALF) ? tjm_pkg::NCO_STEP_NOM + tjm_pkg::NCO_TRIM_MAX :
                 (dm_fill < tjm_pkg::STORE_HALF) ? tjm_pkg::NCO_STEP_NOM - tjm_pkg::NCO_TRIM_MAX :
                 tjm_pkg::NCO_STEP_NOM;
   assign nco_sum = {1'b0, nco_q} + {1'b0, step};
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         nco_q <= 16'h0000;
         smooth_tick <= 1'b0;
      end
      else
      begin
         nco_q <= nco_sum[15:0];
         smooth_tick <= nco_sum[16];
      end
   end

   // -----------------------------------------------------------------
   // fail and activation handling in system clock
   // -----------------------------------------------------------------
   logic fail_s;
   tjm_sync3 fail_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(trail_fail_in_i),
      .q_o(fail_s)
   );
   tjm_pkg::tjm_state_t st_q;
   tjm_pkg::tjm_state_t st_d;
   always_comb
   begin
      case (st_q)
         tjm_pkg::TJM_IDLE: st_d = function_activate_i ? tjm_pkg::TJM_RUN : tjm_pkg::TJM_IDLE;
         tjm_pkg::TJM_RUN: st_d = !function_activate_i ? tjm_pkg::TJM_IDLE :
                                  fail_s ? tjm_pkg::TJM_FAIL : tjm_pkg::TJM_RUN;
         tjm_pkg::TJM_FAIL: st_d = !function_activate_i ? tjm_pkg::TJM_IDLE :
                                   fail_s ? tjm_pkg::TJM_FAIL : tjm_pkg::TJM_RUN;
         default: st_d = tjm_pkg::TJM_IDLE;
      endcase
   end
   logic all_ones_action;
   assign all_ones_action = (st_q != tjm_pkg::TJM_RUN);
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_q <= tjm_pkg::TJM_IDLE;
         tributary_data_out_o <= 1'b1;
         tributary_clk_o <= 1'b0;
         server_fail_out_o <= 1'b0;
         status_valid_o <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         // ones from the next smooth tick, far inside the fail bound
         if (smooth_tick)
            tributary_data_out_o <= all_ones_action ? 1'b1 : dm_rd;
         tributary_clk_o <= smooth_tick;
         server_fail_out_o <= fail_s && function_activate_i;
         status_valid_o <= function_activate_i;
      end
   end
endmodule

// [sim/tjm_agg_model.sv]
module tjm_agg_model (
   input wire logic [1:0] slot_i,
   input wire logic d_i,
   input wire logic just_i,
   output logic clk_o,
   output logic fs_o,
   output logic rx_fs_o,
   output logic rx_d_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // --------------------------------------------------
   // free-running aggregate frame source
   // --------------------------------------------------
   logic [9:0] pos_q = 10'h000;
   logic slot_bit;
   logic ctrl_bit;
   initial
   begin
      clk_o = 1'b0;
      forever #15 clk_o = ~clk_o;
   end
   always @(posedge clk_o)
   begin
      pos_q <= (pos_q == tjm_pkg::FRAME_LAST) ? 10'h000 : pos_q + 10'h001;
   end
   assign fs_o = (pos_q == tjm_pkg::FRAME_LAST);
   // receive start marks the bit before frame bit 0, as the demapper counter expects
   assign rx_fs_o = (pos_q == tjm_pkg::FRAME_LAST);
   assign slot_bit = (pos_q[1:0] == slot_i) && (pos_q >= 10'(tjm_pkg::OVERHEAD_END));
   assign ctrl_bit = (pos_q >= 10'(tjm_pkg::SET_BITS)) &&
      ((pos_q % 10'(tjm_pkg::SET_BITS)) < 10'(tjm_pkg::CTRL_BITS));
   // foreign slots carry the inverse so a wrong pick shows in the data
   assign rx_d_o = slot_bit ? (ctrl_bit ? just_i : d_i) : ~d_i;
endmodule

// [sim/tjm_monitor.sv]
module tjm_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic function_activate_i,
   input wire logic trail_fail_in_i,
   input wire logic tributary_data_out_o,
   input wire logic tributary_clk_o,
   input wire logic server_fail_out_o,
   input wire logic status_valid_o,
   input wire logic aggregate_timing_clock_i,
   input wire logic agg_rst_i,
   input wire logic aggregate_frame_start_i,
   input wire logic map_activate_i,
   input wire logic agg_data_oe_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // --------------------------------------------------
   // blocked span: output may wait one smooth tick
   // --------------------------------------------------
   logic [6:0] blk_q;
   logic [6:0] blk_d;
   assign blk_d = (!function_activate_i || server_fail_out_o) ? blk_q + {6'h00, blk_q != 7'h7f} : 7'h00;
   always_ff @(posedge clk_i)
   begin
      blk_q <= rst_i ? 7'h00 : blk_d;
   end
   status_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |-> status_valid_o == $past(function_activate_i)) else $error("status not activate");
   fail_hidden_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!function_activate_i) [*2] |-> !server_fail_out_o) else $error("fail shown while inactive");
   fail_raise_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (trail_fail_in_i && function_activate_i) [*6] |-> server_fail_out_o) else $error("fail not raised");
   fail_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!trail_fail_in_i) [*6] |-> !server_fail_out_o) else $error("fail not cleared");
   ones_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
      blk_q >= 7'h50 |-> tributary_data_out_o) else $error("output not all ones");
   tick_spacing_a: assert property (@(posedge clk_i) disable iff (rst_i)
      tributary_clk_o |=> (!tributary_clk_o) [*8] ##[1:60] tributary_clk_o) else $error("uneven tick");
   oe_idle_a: assert property (@(posedge aggregate_timing_clock_i) disable iff (agg_rst_i)
      (!map_activate_i) [*4] |-> !agg_data_oe_o) else $error("aggregate driven while inactive");
   oe_overhead_a: assert property (@(posedge aggregate_timing_clock_i) disable iff (agg_rst_i)
      aggregate_frame_start_i |-> ##2 (!agg_data_oe_o) [*8]) else $error("overhead driven");
   oe_interleave_a: assert property (@(posedge aggregate_timing_clock_i) disable iff (agg_rst_i)
      agg_data_oe_o |=> !agg_data_oe_o) else $error("adjacent slot driven");
endmodule
bind tjm_top tjm_monitor u_tjm_monitor (.clk_i, .rst_i, .function_activate_i, .trail_fail_in_i,
   .tributary_data_out_o, .tributary_clk_o, .server_fail_out_o, .status_valid_o, .aggregate_timing_clock_i,
   .agg_rst_i, .aggregate_frame_start_i, .map_activate_i, .agg_data_oe_o);

// [sim/tjm_top_tb.sv]
module tjm_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i, trib_clk_i, agg_clk, fs, rx_fs, rx_d, dout, tclk, sfail, stat, oe;
   logic rst_i = 1'b1;
   logic trib_rst_i = 1'b1;
   logic d = 1'b0;
   logic just = 1'b0;
   logic act = 1'b0;
   logic fail = 1'b0;
   logic map_act = 1'b0;
   logic [1:0] slot = 2'h0;
   int error_cnt = 0;
   int checks = 0;
   int w;
   tjm_top u_tjm_top (.clk_i(clk_i), .rst_i(rst_i), .slot_index_i(slot), .trib_clk_i(trib_clk_i),
      .trib_rst_i(trib_rst_i), .trib_data_i(d), .aggregate_timing_clock_i(agg_clk), .agg_rst_i(rst_i),
      .aggregate_frame_start_i(fs), .map_activate_i(map_act), .agg_data_o(), .agg_data_oe_o(oe),
      .agg_rx_clk_i(agg_clk), .agg_rx_rst_i(rst_i), .agg_rx_data_i(rx_d), .agg_rx_frame_start_i(rx_fs),
      .trail_fail_in_i(fail), .function_activate_i(act), .tributary_data_out_o(dout),
      .tributary_clk_o(tclk), .server_fail_out_o(sfail), .status_valid_o(stat));
   tjm_agg_model u_tjm_agg_model (.slot_i(slot), .d_i(d), .just_i(just), .clk_o(agg_clk), .fs_o(fs),
      .rx_fs_o(rx_fs), .rx_d_o(rx_d));
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial
   begin
      trib_clk_i = 1'b0;
      forever #244 trib_clk_i = ~trib_clk_i;
   end
   task automatic chk(input string name, input logic seen, input logic exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %b seen %b", name, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // --------------------------------------------------
   // wait smooth ticks, then sample where data stands
   // --------------------------------------------------
   task automatic ticks(input int n);
      for (int i = 0; i < n; i++)
      begin
         w = 0;
         do
         begin
            @(negedge clk_i);
            w++;
         end
         while (tclk !== 1'b1 && w < 200);
         chk("tick", tclk, 1'b1);
      end
      repeat (2) @(negedge clk_i);
   endtask
   task automatic do_reset();
      rst_i = 1'b1;
      trib_rst_i = 1'b1;
      repeat (8) @(negedge clk_i);
      chk("data in reset", dout, 1'b1);
      rst_i = 1'b0;
      // slow tributary domain needs three of its own edges in reset
      repeat (3) @(negedge trib_clk_i);
      trib_rst_i = 1'b0;
   endtask
   initial
   begin
      #1ms;
      error_cnt++;
      report_and_stop();
   end
   initial
   begin
      for (int s = 0; s < 4; s++)
      begin
         @(negedge clk_i);
         slot = 2'(s);
         d = slot[0];
         just = slot[1];
         act = 1'b1;
         map_act = 1'b1;
         fail = 1'b0;
         do_reset();
         chk("status", stat, 1'b1);
         w = 0;
         while (oe !== 1'b1 && w < 4000)
         begin
            @(negedge clk_i);
            w++;
         end
         chk("mapper slot", oe, 1'b1);
         ticks(80);
         for (int k = 0; k < 4; k++)
         begin
            chk("slot data", dout, d);
            ticks(1);
         end
         fail = 1'b1;
         repeat (6) @(negedge clk_i);
         chk("fail out", sfail, 1'b1);
         ticks(2);
         chk("ones on fail", dout, 1'b1);
         fail = 1'b0;
         repeat (6) @(negedge clk_i);
         chk("fail cleared", sfail, 1'b0);
         ticks(2);
         chk("data resumed", dout, d);
         fail = 1'b1;
         act = 1'b0;
         map_act = 1'b0;
         ticks(2);
         chk("status hidden", stat, 1'b0);
         chk("fail hidden", sfail, 1'b0);
         chk("ones inactive", dout, 1'b1);
         chk("mapper idle", oe, 1'b0);
      end
      report_and_stop();
   end
endmodule
